// file: rtl/gtc_defines.svh
// constants for the gated 16-bit timer counter
`ifndef GTC_DEFINES_SVH
`define GTC_DEFINES_SVH
`define GTC_ADDR_W        3
`define GTC_OFF_CNT_LO    3'h0
`define GTC_OFF_CNT_HI    3'h1
`define GTC_OFF_CTRL      3'h2
`define GTC_OFF_GATE      3'h3
`define GTC_OFF_FLAGS     3'h4
`define GTC_OFF_SRC       3'h5
`define GTC_CTRL_RUN      0
`define GTC_CTRL_WIDE     1
`define GTC_CTRL_NOSYNC   2
`define GTC_CTRL_PS_LO    4
`define GTC_CTRL_OSC_EN   6
`define GTC_GATE_LEVEL    2
`define GTC_GATE_ARM      3
`define GTC_GATE_SPM      4
`define GTC_GATE_TOGGLE   5
`define GTC_GATE_POL      6
`define GTC_GATE_EN       7
`define GTC_FLAG_OVF      0
`define GTC_FLAG_GATE     1
`define GTC_FLAG_OVF_IE   2
`define GTC_FLAG_GATE_IE  3
`define GTC_SRC_GSS_LO    4
`define GTC_CNT_RESET     16'h0000
`define GTC_CNT_MAX       16'hFFFF
`define GTC_OSC_FREQ_HZ   32768
`endif

// file: rtl/gtc_pkg.sv
// types for the gated 16-bit timer counter
package gtc_pkg;
  typedef enum logic [1:0] {
    GTC_CLK_SYS,
    GTC_CLK_SYS_DIV4,
    GTC_CLK_EXT,
    GTC_CLK_OSC
  } gtc_clk_src_e;
  typedef enum logic [1:0] {
    GTC_GATE_PIN,
    GTC_GATE_CMP_SYNC,
    GTC_GATE_CMP_ASYNC,
    GTC_GATE_PERIPH
  } gtc_gate_src_e;
endpackage : gtc_pkg

// file: rtl/gtc_sync.sv
// two-flop synchroniser for a level
`timescale 1ns/1ns
`default_nettype none
module gtc_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // level in and out
  input  wire logic d_in,
  output var  logic q_out
);
  logic meta_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= 1'b0;
      q_out    <= 1'b0;
    end else begin
      meta_reg <= d_in;
      q_out    <= meta_reg;
    end
  end
endmodule : gtc_sync
`default_nettype wire

// file: rtl/gtc_prescaler.sv
// count-clock prescaler dividing by 1, 2, 4 or 8
`timescale 1ns/1ns
`default_nettype none
module gtc_prescaler #(
  parameter int PS_W = 3
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // control
  input  wire logic [1:0] prescale_select,
  input  wire logic       clear,
  input  wire logic       tick_in,
  // divided tick
  output logic            tick_out
);
  logic [PS_W-1:0] cnt_reg;
  logic [PS_W-1:0] mask;
  always_comb begin
    case (prescale_select)
      2'h0:    mask = 3'h0;
      2'h1:    mask = 3'h1;
      2'h2:    mask = 3'h3;
      default: mask = 3'h7;
    endcase
  end
  assign tick_out = tick_in && ((cnt_reg & mask) == mask);
  always_ff @(posedge clk) begin
    if (rst || clear) begin
      cnt_reg <= '0;
    end else if (tick_in) begin
      cnt_reg <= cnt_reg + 3'h1;
    end
  end
endmodule : gtc_prescaler
`default_nettype wire

// file: rtl/gtc_timer.sv
// gated 16-bit timer counter with byte-wide register port
// Overview of operation
// - prescale count clock by 1, 2, 4, 8
// - prescaler hidden, cleared on low count write
// - low-frequency oscillator clock selectable, runs while enable bit set
// - bypass bit counts external clock unsynchronised
// - sync mode switch may skip/add one
// - each byte read returns valid value
// - wide mode routes high byte via buffer
// - low read snapshots high into buffer
// - low write loads buffer and low together
// - high write keeps prescaler, low clears
// - gated count only while gate matches polarity
// - gate source select then polarity applied
// - toggle flip-flop, cleared when mode off
// - single pulse arm, count, clear at trailing
// - leaving single pulse clears arm bit
// - toggle plus single pulse measures cycle
// - gate level status always readable
// - gate flag on level fall, interrupt enable
// - rollover FFFF to 0000 sets overflow
// - run bit and gate enable select counting
// - counter mode needs falling edge first
// - bypass ignored for system clock sources
//
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "gtc_defines.svh"
module gtc_timer #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // register port
  input  wire logic [`GTC_ADDR_W-1:0] addr,
  input  wire logic [7:0]             wdata,
  input  wire logic                   wr_stb,
  input  wire logic                   rd_stb,
  output logic      [7:0]             rdata,
  // count clock sources
  input  wire logic                   external_count_input,
  input  wire logic                   crystal_in_pin,
  output logic                        crystal_amp_out_pin,
  // gate sources
  input  wire logic                   gate_input,
  input  wire logic                   cmp_gate_in,
  input  wire logic                   periph_gate_in,
  // interrupts and sleep wake
  output logic                        overflow_irq,
  output logic                        gate_event_irq,
  output logic                        wake_out
);
  // control registers
  logic       run_reg;
  logic       wide_access_enable_reg;
  logic       nosync_reg;
  logic [1:0] prescale_select_reg;
  logic       low_freq_osc_enable_reg;
  logic       gating_enable_reg;
  logic       gate_polarity_reg;
  logic       gate_toggle_mode_reg;
  logic       gate_single_pulse_mode_reg;
  logic       single_pulse_arm_reg;
  logic       overflow_flag_reg;
  logic       gate_event_flag_reg;
  logic       overflow_irq_enable_reg;
  logic       gate_event_irq_enable_reg;
  gtc_pkg::gtc_clk_src_e  clk_src_reg;
  gtc_pkg::gtc_gate_src_e gate_src_reg;
  // counter datapath
  logic [CNT_W-1:0] count_reg;
  logic [7:0]       hi_buf_reg;
  logic [7:0]       rdata_reg;
  // count clock edge detection
  logic src_level;
  logic src_prev_reg;
  logic fall_seen_reg;
  logic [1:0] div4_reg;
  logic raw_tick;
  logic ps_tick;
  // gate path
  logic gate_sel;
  logic gate_pol;
  logic gate_pol_prev_reg;
  logic toggle_ff_reg;
  logic gate_toggled;
  logic spm_active_reg;
  logic gate_level_status;
  logic gate_level_prev_reg;
  logic gate_allows;
  logic count_en;
  logic cnt_wr_lo;
  logic cnt_wr_hi;
  logic cnt_wr_any;
  logic rd_lo;
  logic status_prev_reg;
  // crystal amplifier: inverted input while enabled
  // oscillator enable
  assign crystal_amp_out_pin = low_freq_osc_enable_reg & ~crystal_in_pin;

  logic [2:0] sync_in;
  logic [2:0] sync_out;
  assign sync_in = {cmp_gate_in, crystal_in_pin, external_count_input};
  for (genvar g = 0; g < 3; g++) begin : g_sync
    gtc_sync u_gtc_sync (
      .clk   (clk),
      .rst   (rst),
      .d_in  (sync_in[g]),
      .q_out (sync_out[g])
    );
  end

  // one clock domain only, so bypass still samples pins directly;
  // this trades metastability margin for two fewer cycles of delay
  // bypass sampling
  always_comb begin
    case (clk_src_reg)
      gtc_pkg::GTC_CLK_EXT: src_level = nosync_reg ? external_count_input : sync_out[0];
      gtc_pkg::GTC_CLK_OSC: src_level = nosync_reg ? crystal_in_pin : sync_out[1];
      default:              src_level = 1'b0;
    endcase
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      div4_reg <= 2'h0;
    end else begin
      div4_reg <= div4_reg + 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      src_prev_reg  <= 1'b0;
      fall_seen_reg <= 1'b0;
    end else begin
      src_prev_reg <= src_level;
      if (!run_reg || cnt_wr_any) begin
        fall_seen_reg <= 1'b0;
      end else if (src_prev_reg && !src_level) begin
        fall_seen_reg <= 1'b1;
      end
    end
  end

  // a sync switch may drop or add one edge
  always_comb begin
    case (clk_src_reg)
      gtc_pkg::GTC_CLK_SYS:      raw_tick = 1'b1;
      gtc_pkg::GTC_CLK_SYS_DIV4: raw_tick = (div4_reg == 2'h3);
      default:                   raw_tick = fall_seen_reg && !src_prev_reg && src_level;
    endcase
  end
  gtc_prescaler #(
    .PS_W (3)
  ) u_prescaler (
    .clk             (clk),
    .rst             (rst),
    .prescale_select (prescale_select_reg),
    .clear           (cnt_wr_lo),
    .tick_in         (raw_tick && count_en),
    .tick_out        (ps_tick)
  );

  always_comb begin
    case (gate_src_reg)
      gtc_pkg::GTC_GATE_PIN:       gate_sel = gate_input;
      gtc_pkg::GTC_GATE_CMP_SYNC:  gate_sel = sync_out[2];
      gtc_pkg::GTC_GATE_CMP_ASYNC: gate_sel = cmp_gate_in;
      default:                     gate_sel = periph_gate_in;
    endcase
  end
  assign gate_pol = gate_polarity_reg ? gate_sel : ~gate_sel;

  always_ff @(posedge clk) begin
    if (rst) begin
      gate_pol_prev_reg <= 1'b0;
      toggle_ff_reg     <= 1'b0;
    end else begin
      gate_pol_prev_reg <= gate_pol;
      if (!gate_toggle_mode_reg) begin
        toggle_ff_reg <= 1'b0;
      end else if (gate_pol && !gate_pol_prev_reg) begin
        toggle_ff_reg <= ~toggle_ff_reg;
      end
    end
  end
  assign gate_toggled = gate_toggle_mode_reg ? toggle_ff_reg : gate_pol;

  always_ff @(posedge clk) begin
    if (rst || !gate_single_pulse_mode_reg || !single_pulse_arm_reg) begin
      spm_active_reg <= 1'b0;
    end else if (gate_toggled && !gate_level_prev_reg) begin
      spm_active_reg <= 1'b1;
    end
  end

  assign gate_level_status = gate_single_pulse_mode_reg ? (spm_active_reg && gate_toggled) : gate_toggled;

  always_ff @(posedge clk) begin
    if (rst) begin
      gate_level_prev_reg <= 1'b0;
      status_prev_reg     <= 1'b0;
    end else begin
      gate_level_prev_reg <= gate_toggled;
      status_prev_reg     <= gate_level_status;
    end
  end

  assign gate_allows = gating_enable_reg ? gate_level_status : 1'b1;
  assign count_en = run_reg && gate_allows;

  assign cnt_wr_lo  = wr_stb && (addr == `GTC_OFF_CNT_LO);
  assign cnt_wr_hi  = wr_stb && (addr == `GTC_OFF_CNT_HI);
  assign cnt_wr_any = cnt_wr_lo || (cnt_wr_hi && !wide_access_enable_reg);
  assign rd_lo      = rd_stb && (addr == `GTC_OFF_CNT_LO);
  // a write in an increment cycle wins
  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg <= `GTC_CNT_RESET;
    end else if (cnt_wr_lo) begin
      if (wide_access_enable_reg) begin
        count_reg <= {hi_buf_reg, wdata};
      end else begin
        count_reg <= {count_reg[15:8], wdata};
      end
    end else if (cnt_wr_hi && !wide_access_enable_reg) begin
      count_reg <= {wdata, count_reg[7:0]};
    end else if (ps_tick) begin
      count_reg <= count_reg + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      hi_buf_reg <= 8'h00;
    end else if (wide_access_enable_reg && cnt_wr_hi) begin
      hi_buf_reg <= wdata;
    end else if (wide_access_enable_reg && rd_lo) begin
      hi_buf_reg <= count_reg[15:8];
    end
  end

  // control register writes
  // arm cleared with single pulse mode
  always_ff @(posedge clk) begin
    if (rst) begin
      run_reg                    <= 1'b0;
      wide_access_enable_reg     <= 1'b0;
      nosync_reg                 <= 1'b0;
      prescale_select_reg        <= 2'h0;
      low_freq_osc_enable_reg    <= 1'b0;
      gating_enable_reg          <= 1'b0;
      gate_polarity_reg          <= 1'b0;
      gate_toggle_mode_reg       <= 1'b0;
      gate_single_pulse_mode_reg <= 1'b0;
      single_pulse_arm_reg       <= 1'b0;
      overflow_irq_enable_reg    <= 1'b0;
      gate_event_irq_enable_reg  <= 1'b0;
      clk_src_reg                <= gtc_pkg::GTC_CLK_SYS_DIV4;
      gate_src_reg               <= gtc_pkg::GTC_GATE_PIN;
    end else begin
      if (wr_stb && addr == `GTC_OFF_CTRL) begin
        run_reg                 <= wdata[`GTC_CTRL_RUN];
        wide_access_enable_reg  <= wdata[`GTC_CTRL_WIDE];
        nosync_reg              <= wdata[`GTC_CTRL_NOSYNC];
        prescale_select_reg     <= wdata[`GTC_CTRL_PS_LO +: 2];
        low_freq_osc_enable_reg <= wdata[`GTC_CTRL_OSC_EN];
      end
      if (wr_stb && addr == `GTC_OFF_GATE) begin
        gating_enable_reg          <= wdata[`GTC_GATE_EN];
        gate_polarity_reg          <= wdata[`GTC_GATE_POL];
        gate_toggle_mode_reg       <= wdata[`GTC_GATE_TOGGLE];
        gate_single_pulse_mode_reg <= wdata[`GTC_GATE_SPM];
        single_pulse_arm_reg       <= wdata[`GTC_GATE_ARM] && wdata[`GTC_GATE_SPM];
      end else if (!gate_single_pulse_mode_reg) begin
        single_pulse_arm_reg <= 1'b0;
      end else if (spm_active_reg && !gate_toggled) begin
        single_pulse_arm_reg <= 1'b0;
      end
      if (wr_stb && addr == `GTC_OFF_FLAGS) begin
        overflow_irq_enable_reg   <= wdata[`GTC_FLAG_OVF_IE];
        gate_event_irq_enable_reg <= wdata[`GTC_FLAG_GATE_IE];
      end
      if (wr_stb && addr == `GTC_OFF_SRC) begin
        clk_src_reg  <= gtc_pkg::gtc_clk_src_e'(wdata[1:0]);
        gate_src_reg <= gtc_pkg::gtc_gate_src_e'(wdata[`GTC_SRC_GSS_LO +: 2]);
      end
    end
  end

  // flags: hardware set wins over software clear
  // gate event on level fall
  always_ff @(posedge clk) begin
    if (rst) begin
      overflow_flag_reg   <= 1'b0;
      gate_event_flag_reg <= 1'b0;
    end else begin
      if (ps_tick && count_reg == `GTC_CNT_MAX && !cnt_wr_any) begin
        overflow_flag_reg <= 1'b1;
      end else if (wr_stb && addr == `GTC_OFF_FLAGS) begin
        overflow_flag_reg <= wdata[`GTC_FLAG_OVF];
      end
      if (status_prev_reg && !gate_level_status) begin
        gate_event_flag_reg <= 1'b1;
      end else if (wr_stb && addr == `GTC_OFF_FLAGS) begin
        gate_event_flag_reg <= wdata[`GTC_FLAG_GATE];
      end
    end
  end

  assign overflow_irq   = overflow_flag_reg && overflow_irq_enable_reg;
  assign gate_event_irq = gate_event_flag_reg && gate_event_irq_enable_reg;
  // overflow can wake when unsynchronised external counting
  assign wake_out = overflow_irq && nosync_reg &&
                    (clk_src_reg == gtc_pkg::GTC_CLK_EXT || clk_src_reg == gtc_pkg::GTC_CLK_OSC);

  // reads come from one registered sample
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_reg <= 8'h00;
    end else if (rd_stb) begin
      if (addr == `GTC_OFF_CNT_LO) begin
        rdata_reg <= count_reg[7:0];
      end else if (addr == `GTC_OFF_CNT_HI) begin
        rdata_reg <= wide_access_enable_reg ? hi_buf_reg : count_reg[15:8];
      end else if (addr == `GTC_OFF_CTRL) begin
        rdata_reg <= {1'b0, low_freq_osc_enable_reg, prescale_select_reg, 1'b0,
                      nosync_reg, wide_access_enable_reg, run_reg};
      end else if (addr == `GTC_OFF_GATE) begin
        rdata_reg <= {gating_enable_reg, gate_polarity_reg, gate_toggle_mode_reg,
                      gate_single_pulse_mode_reg, single_pulse_arm_reg, gate_level_status, 2'h0};
      end else if (addr == `GTC_OFF_FLAGS) begin
        rdata_reg <= {4'h0, gate_event_irq_enable_reg, overflow_irq_enable_reg,
                      gate_event_flag_reg, overflow_flag_reg};
      end else if (addr == `GTC_OFF_SRC) begin
        rdata_reg <= {2'h0, gate_src_reg, 2'h0, clk_src_reg};
      end else begin
        rdata_reg <= 8'h00;
      end
    end else begin
      rdata_reg <= 8'h00;
    end
  end
  assign rdata = rdata_reg;
endmodule : gtc_timer
`default_nettype wire

// file: testbench/gtc_timer_chk.sv
// port-level assertions for the gated timer counter
`timescale 1ns/1ns
`default_nettype none
`include "gtc_defines.svh"
module gtc_timer_chk #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic                   clk,
  input wire logic                   rst,
  // register port
  input wire logic [`GTC_ADDR_W-1:0] addr,
  input wire logic [7:0]             wdata,
  input wire logic                   wr_stb,
  input wire logic                   rd_stb,
  input wire logic [7:0]             rdata,
  // oscillator pins and outputs
  input wire logic                   crystal_in_pin,
  input wire logic                   crystal_amp_out_pin,
  input wire logic                   overflow_irq,
  input wire logic                   gate_event_irq,
  input wire logic                   wake_out
);
  logic [7:0] ctrl_reg;
  logic [1:0] ie_reg;

  // software copies; only written bits are known outside the block
  always_ff @(posedge clk) begin
    if (rst) ctrl_reg <= 8'h00;
    else if (wr_stb && addr == `GTC_OFF_CTRL) ctrl_reg <= wdata;
  end
  always_ff @(posedge clk) begin
    if (rst) ie_reg <= 2'h0;
    else if (wr_stb && addr == `GTC_OFF_FLAGS) ie_reg <= wdata[3:2];
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence spm_off;
    wr_stb && addr == `GTC_OFF_GATE && !wdata[`GTC_GATE_SPM];
  endsequence
  sequence gate_rd;
    rd_stb && addr == `GTC_OFF_GATE;
  endsequence

  reset_quiet_a: assert property (disable iff (1'b0) rst |=> rdata == 8'h00 && !overflow_irq && !wake_out
    && !gate_event_irq && !crystal_amp_out_pin) else $error("outputs active after reset");
  rdata_idle_a: assert property (!rd_stb |=> rdata == 8'h00) else $error("read data outside read cycle");
  unmapped_read_a: assert property (rd_stb && addr >= 3'h6 |=> rdata == 8'h00) else $error("unmapped read not zero");
  ctrl_readback_a: assert property (rd_stb && addr == `GTC_OFF_CTRL |=> rdata[6:4] == ctrl_reg[6:4]
    && rdata[2:0] == ctrl_reg[2:0]) else $error("control readback differs");
  ie_readback_a: assert property (rd_stb && addr == `GTC_OFF_FLAGS |=> rdata[3:2] == ie_reg)
    else $error("enable readback differs");
  ovf_irq_gate_a: assert property (overflow_irq |-> ie_reg[0]) else $error("overflow irq without enable");
  gev_irq_gate_a: assert property (gate_event_irq |-> ie_reg[1]) else $error("gate irq without enable");
  ovf_clear_a: assert property (wr_stb && addr == `GTC_OFF_FLAGS && !wdata[0] && !ctrl_reg[0]
    |=> !overflow_irq) else $error("overflow irq survives clear");
  wake_cause_a: assert property (wake_out |-> overflow_irq && ctrl_reg[`GTC_CTRL_NOSYNC])
    else $error("wake without bypass overflow");
  osc_amp_a: assert property (crystal_amp_out_pin |-> ctrl_reg[`GTC_CTRL_OSC_EN] && !crystal_in_pin)
    else $error("oscillator amplifier wrong");
  arm_drop_a: assert property (spm_off ##2 gate_rd |=> !rdata[`GTC_GATE_ARM])
    else $error("arm bit kept without single pulse");
endmodule : gtc_timer_chk

bind gtc_timer gtc_timer_chk #(.CNT_W(CNT_W)) u_gtc_timer_chk (.clk(clk), .rst(rst), .addr(addr),
  .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .crystal_in_pin(crystal_in_pin),
  .crystal_amp_out_pin(crystal_amp_out_pin), .overflow_irq(overflow_irq),
  .gate_event_irq(gate_event_irq), .wake_out(wake_out));
`default_nettype wire

// file: testbench/gtc_src_model.sv
// count clock and gate source outside the timer
`timescale 1ns/1ns
`default_nettype none
module gtc_src_model (
  // clock
  input  wire logic clk,
  // count clock and gate levels
  output var  logic count_clk,
  output var  logic gate_lvl
);
  initial begin
    count_clk = 1'b1;
    gate_lvl  = 1'b0;
  end
  // idles high so each pulse leads with a falling edge
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk) count_clk <= 1'b0;
      repeat (4) @(posedge clk);
      count_clk <= 1'b1;
      repeat (4) @(posedge clk);
    end
    // settle time covers synchroniser and prescaler latency
    repeat (6) @(posedge clk);
  endtask : pulses
  task automatic set_gate(input logic v);
    @(posedge clk) gate_lvl <= v;
    repeat (6) @(posedge clk);
  endtask : set_gate
  task automatic set_clk(input logic v);
    @(posedge clk) count_clk <= v;
    repeat (6) @(posedge clk);
  endtask : set_clk
endmodule : gtc_src_model
`default_nettype wire

// file: testbench/tb.sv
// self-checking bench for the gated timer counter
`timescale 1ns/1ns
`default_nettype none
`include "gtc_defines.svh"
module tb;
  localparam logic [2:0] A_LO = `GTC_OFF_CNT_LO;
  localparam logic [2:0] A_HI = `GTC_OFF_CNT_HI;
  localparam logic [2:0] A_CT = `GTC_OFF_CTRL;
  localparam logic [2:0] A_GT = `GTC_OFF_GATE;
  localparam logic [2:0] A_FL = `GTC_OFF_FLAGS;
  localparam logic [2:0] A_SR = `GTC_OFF_SRC;
  logic       clk;
  logic       rst;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic       wr_stb;
  logic       rd_stb;
  logic [7:0] rdata;
  logic       count_clk;
  logic       gate_lvl;
  logic       amp_out;
  logic       ovf_irq;
  logic       gev_irq;
  logic       wake;
  logic [7:0] rv;
  int         bad_count;
  int         comparisons;
  int         cycles;
  int         ps;

  always #20 clk = ~clk;

  gtc_timer #(.CNT_W(16)) u_gtc_timer (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .external_count_input(count_clk), .crystal_in_pin(count_clk),
    .crystal_amp_out_pin(amp_out), .gate_input(gate_lvl), .cmp_gate_in(gate_lvl),
    .periph_gate_in(gate_lvl), .overflow_irq(ovf_irq), .gate_event_irq(gev_irq), .wake_out(wake));
  gtc_src_model u_gtc_src_model (.clk(clk), .count_clk(count_clk), .gate_lvl(gate_lvl));

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask : rd
  // low byte first, as wide mode snapshots the high byte there
  task automatic cnt_is(input logic [15:0] exp);
    logic [15:0] v;
    rd(A_LO, v[7:0]);
    rd(A_HI, v[15:8]);
    chk("count", exp, v);
  endtask : cnt_is
  task automatic pulses(input int n);
    u_gtc_src_model.pulses(n);
  endtask : pulses
  task automatic gate(input logic v);
    u_gtc_src_model.set_gate(v);
  endtask : gate
  task automatic results;
    if (bad_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      results();
    end
  end

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    addr = 3'h0;
    wdata = 8'h00;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(A_SR, rv);
    chk("source reset", 16'h0001, {8'h00, rv});
    rd(3'h6, rv);
    chk("unmapped", 16'h0000, {8'h00, rv});
    wr(A_SR, 8'h02);
    for (ps = 0; ps < 4; ps++) begin
      wr(A_CT, 8'h00);
      wr(A_HI, 8'h00);
      wr(A_LO, 8'h00);
      wr(A_CT, 8'h01 | (8'(ps) << 4));
      pulses(8);
      cnt_is(16'(8 >> ps));
      pulses((1 << ps) - 1);
      // count written with no count edge in flight
      wr(A_LO, 8'h00);
      pulses((1 << ps) - 1);
      cnt_is(16'h0000);
      pulses(1);
      cnt_is(16'h0001);
    end
    pulses(4);
    wr(A_HI, 8'h05);
    pulses(4);
    cnt_is(16'h0502);
    wr(A_CT, 8'h06);
    wr(A_HI, 8'hFF);
    cnt_is(16'h0502);
    wr(A_HI, 8'hFF);
    wr(A_LO, 8'hFE);
    wr(A_CT, 8'h07);
    pulses(1);
    rd(A_LO, rv);
    chk("low byte", 16'h00FF, {8'h00, rv});
    pulses(1);
    rd(A_HI, rv);
    chk("high buffer", 16'h00FF, {8'h00, rv});
    cnt_is(16'h0000);
    wr(A_CT, 8'h06);
    wr(A_FL, 8'h05);
    chk("overflow irq", 16'h0001, {15'h0, ovf_irq});
    chk("wake", 16'h0001, {15'h0, wake});
    wr(A_SR, 8'h00);
    chk("wake sys", 16'h0000, {15'h0, wake});
    wr(A_SR, 8'h02);
    wr(A_FL, 8'h04);
    chk("overflow clr", 16'h0000, {15'h0, ovf_irq});
    wr(A_CT, 8'h01);
    wr(A_GT, 8'hC0);
    pulses(3);
    cnt_is(16'h0000);
    gate(1'b1);
    pulses(3);
    cnt_is(16'h0003);
    wr(A_GT, 8'h80);
    pulses(2);
    cnt_is(16'h0003);
    wr(A_CT, 8'h00);
    wr(A_GT, 8'h00);
    pulses(2);
    cnt_is(16'h0003);
    wr(A_GT, 8'h40);
    for (ps = 0; ps < 4; ps++) begin
      wr(A_SR, (8'(ps) << 4) | 8'h02);
      gate(1'b1);
      rd(A_GT, rv);
      chk("gate level", 16'h0001, {15'h0, rv[2]});
      gate(1'b0);
      rd(A_GT, rv);
      chk("gate level", 16'h0000, {15'h0, rv[2]});
    end
    rd(A_FL, rv);
    chk("gate flag", 16'h0001, {15'h0, rv[1]});
    wr(A_FL, 8'h08);
    gate(1'b1);
    gate(1'b0);
    chk("gate irq", 16'h0001, {15'h0, gev_irq});
    wr(A_FL, 8'h00);
    // toggle enabled with polarity left as it was
    wr(A_GT, 8'h60);
    gate(1'b1);
    gate(1'b0);
    rd(A_GT, rv);
    chk("toggle level", 16'h0001, {15'h0, rv[2]});
    wr(A_GT, 8'h40);
    wr(A_GT, 8'h60);
    rd(A_GT, rv);
    chk("toggle clear", 16'h0000, {15'h0, rv[2]});
    wr(A_LO, 8'h00);
    wr(A_CT, 8'h01);
    wr(A_GT, 8'hD0);
    wr(A_GT, 8'hD8);
    pulses(2);
    cnt_is(16'h0000);
    gate(1'b1);
    pulses(2);
    gate(1'b0);
    rd(A_GT, rv);
    chk("arm done", 16'h0000, {15'h0, rv[3]});
    gate(1'b1);
    pulses(2);
    cnt_is(16'h0002);
    gate(1'b0);
    wr(A_GT, 8'hD8);
    wr(A_GT, 8'h80);
    rd(A_GT, rv);
    chk("arm cleared", 16'h0000, {15'h0, rv[3]});
    wr(A_LO, 8'h00);
    wr(A_GT, 8'hF8);
    gate(1'b1);
    pulses(1);
    gate(1'b0);
    pulses(1);
    gate(1'b1);
    pulses(1);
    cnt_is(16'h0002);
    wr(A_CT, 8'h00);
    wr(A_GT, 8'h00);
    wr(A_LO, 8'h00);
    wr(A_SR, 8'h03);
    // oscillator enabled before the timer is switched on
    wr(A_CT, 8'h40);
    u_gtc_src_model.set_clk(1'b0);
    chk("amp low", 16'h0001, {15'h0, amp_out});
    wr(A_CT, 8'h41);
    u_gtc_src_model.set_clk(1'b1);
    cnt_is(16'h0000);
    pulses(2);
    cnt_is(16'h0002);
    chk("amp out", 16'h0000, {15'h0, amp_out});
    results();
  end
endmodule : tb
`default_nettype wire
